// *** hdl/dac_loader_cfg.svh ***
// Field positions, register offsets and reset values of the word loader.
`ifndef DAC_LOADER_CFG_SVH
`define DAC_LOADER_CFG_SVH

// Serial word layout.
`define WORD_BITS         16
`define CNT_BITS          5
`define CNT_FULL          5'h10
`define CNT_ONE           5'h01
`define CNT_ZERO          5'h00
`define SELECT_HIGH_POS   15
`define SPEED_CHOICE_POS  14
`define POWER_DOWN_POS    13
`define SELECT_LOW_POS    12
`define CODE_MSB_POS      11
`define CODE_LSB_POS      2
`define CODE_BITS         10

// Reset values.
`define CODE_RST          10'h000
`define WORD_RST          16'h0000
`define COUNT_RST         16'h0000
`define BUS_DATA_RST      32'h0000_0000

// Register bus.
`define BUS_ADDR_BITS     5
`define BUS_DATA_BITS     32
`define OFS_CHAN_A        5'h00
`define OFS_CHAN_B        5'h04
`define OFS_HOLD          5'h08
`define OFS_STATUS        5'h0C
`define OFS_SOFT_WORD     5'h10
`define OFS_WORD_COUNT    5'h14
`define OFS_LAST_WORD     5'h18
`define SOFT_LANES        4'h3

// Status register fields.
`define STAT_FAST_POS     0
`define STAT_PDOWN_POS    1
`define STAT_FRAME_POS    2
`define STAT_RSVD_POS     3
`define STAT_BITS         4

`endif

// *** hdl/dac_loader_pkg.sv ***
// Types shared by the word loader files.
`include "dac_loader_cfg.svh"

package dac_loader_pkg;

   typedef enum logic [1:0] {
      SEL_CHAN_B_HOLD = 2'h0,
      SEL_HOLD_ONLY   = 2'h1,
      SEL_CHAN_A_SYNC = 2'h2,
      SEL_RESERVED    = 2'h3
   } select_code_e;

   typedef enum logic {
      BUS_IDLE  = 1'b0,
      BUS_RDATA = 1'b1
   } bus_state_e;

   typedef logic [`CODE_BITS-1:0] code_t;
   typedef logic [`WORD_BITS-1:0] word_t;

endpackage

// *** hdl/bit_sync.sv ***
// Two-flop level synchroniser into the system clock domain.
`timescale 1ns/1ps

module bit_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // System clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Level from the far domain
   input  wire logic [WIDTH-1:0] async_in,
   // Synchronised level
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second one.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// *** hdl/serial_front.sv ***
// Link-clock shift register, bit counter and word hand-off.
`timescale 1ns/1ps
`include "dac_loader_cfg.svh"

module serial_front (
   // Link pins
   input  wire logic                  sclk,
   input  wire logic                  cs_b,
   input  wire logic                  din,
   // Reset driven from the system domain
   input  wire logic                  link_rst_b,
   // Quasi-static state, read only after select has risen
   output logic [`WORD_BITS-1:0]      shift_q,
   output logic [`CNT_BITS-1:0]       cnt_q,
   // Completed word and its toggle event
   output logic [`WORD_BITS-1:0]      word_q,
   output logic                       done_tgl_q
);

   logic armed_q;
   logic posted_q;
   wire  arm_set = cs_b | ~link_rst_b;
   wire  full    = (cnt_q == `CNT_FULL);
   wire  take    = ~cs_b & (armed_q | ~full);
   wire  post    = full & ~posted_q;

   // Select high re-arms the sequencer without needing a clock edge.
   always_ff @(negedge sclk or posedge arm_set) begin
      if (arm_set) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= 1'b0;
      end
   end

   // Bits are taken only while select is low, and never past sixteen.
   always_ff @(negedge sclk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         cnt_q   <= `CNT_ZERO;
         shift_q <= `WORD_RST;
      end else if (take) begin // see [RULE_13] see [RULE_14]
         cnt_q   <= armed_q ? `CNT_ONE : cnt_q + `CNT_ONE; // see [RULE_01]
         shift_q <= armed_q ? {{(`WORD_BITS-1){1'b0}}, din}
                            : {shift_q[`WORD_BITS-2:0], din}; // see [RULE_01]
      end
   end

   // The rising edge after the last bit posts the word once per frame.
   always_ff @(posedge sclk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         posted_q   <= 1'b0;
         word_q     <= `WORD_RST;
         done_tgl_q <= 1'b0;
      end else begin
         posted_q <= full; // see [RULE_10]
         if (post) begin // see [RULE_02] see [RULE_06]
            word_q     <= shift_q;
            done_tgl_q <= ~done_tgl_q;
         end
      end
   end

endmodule

// *** hdl/dual_dac_serial_word_loader.sv ***
// Serial word loader of a dual converter with an Avalon-MM register view.
//
// Function
// [RULE_01] Select falling starts a word; bits sampled on falling clock, MSB first.
// [RULE_02] After sixteen bits or select rising, move the word to its target.
// [RULE_03] Word: program bits 15..12, code bits 11..2, bits 1..0 zero.
// [RULE_04] Select pair 00 chan B+hold, 01 hold, 10 chan A+sync, 11 reserved.
// [RULE_05] Pair 10 moves hold into channel B together with channel A.
// [RULE_06] Channel latches change after the rising clock following bit zero.
// [RULE_07] Bit 14 one picks fast settling, zero picks slow settling.
// [RULE_08] Bit 13 set enters power-down; other bits are ignored then.
// [RULE_09] Reset clears both channels, hold and control to zero.
// [RULE_10] Host gives one extra rising clock after the last bit.
// [RULE_11] Byte-wide hosts send two bytes under one low select.
// [RULE_12] Hold and control update when select rises ending the write; the code loads them with the channel latches once a full word is posted.
// [RULE_13] Serial clock and data are ignored while select is high.
// [RULE_14] Falling clocks after sixteen bits leave latches unchanged.
// [RULE_15] Reserved select code 11 leaves every latch unchanged; the code still enters power-down for such a word when bit 13 is set.
`timescale 1ns/1ps
`include "dac_loader_cfg.svh"

module dual_dac_serial_word_loader #(
   parameter int COUNT_BITS = 16
) (
   // System clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_b,

   // Avalon-MM slave
   input  wire logic [`BUS_ADDR_BITS-1:0]   avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [3:0]                  avs_byteenable,
   input  wire logic [`BUS_DATA_BITS-1:0]   avs_writedata,
   output logic      [`BUS_DATA_BITS-1:0]   avs_readdata,
   output logic                             avs_waitrequest,

   // Serial link pins
   input  wire logic                        sclk,
   input  wire logic                        cs_b,
   input  wire logic                        din,

   // Converter latches
   output logic      [`CODE_BITS-1:0]       chan_a_code,
   output logic      [`CODE_BITS-1:0]       chan_b_code,
   output logic      [`CODE_BITS-1:0]       hold_code,
   output logic                             speed_fast,
   output logic                             power_down
);

   // Link domain hand-off.
   logic                          link_rst_q;
   logic [`WORD_BITS-1:0]         link_shift;
   logic [`CNT_BITS-1:0]          link_cnt;
   logic [`WORD_BITS-1:0]         link_word;
   logic                          link_tgl;

   // Synchronised link levels and their previous values.
   logic                          tgl_s;
   logic                          cs_s;
   logic                          tgl_prev_q;
   logic                          cs_prev_q;

   // Latches and bookkeeping.
   logic [`CODE_BITS-1:0]         chan_a_q;
   logic [`CODE_BITS-1:0]         chan_b_q;
   logic [`CODE_BITS-1:0]         hold_q;
   logic                          speed_q;
   logic                          pdown_q;
   logic                          rsvd_seen_q;
   logic [COUNT_BITS-1:0]         word_count_q;
   logic [`WORD_BITS-1:0]         last_word_q;

   // Register bus state.
   dac_loader_pkg::bus_state_e    bus_state_q;
   logic [`BUS_DATA_BITS-1:0]     rdata_q;

   // Link logic is held in reset for as long as the system reset lasts.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link_rst_q <= 1'b0;
      end else begin
         link_rst_q <= 1'b1;
      end
   end

   serial_front u_front (
      .sclk       (sclk),
      .cs_b       (cs_b),
      .din        (din),
      .link_rst_b (link_rst_q),
      .shift_q    (link_shift),
      .cnt_q      (link_cnt),
      .word_q     (link_word),
      .done_tgl_q (link_tgl)
   );

   bit_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) u_tgl_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (link_tgl),
      .sync_out (tgl_s)
   );

   bit_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_cs_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (cs_b),
      .sync_out (cs_s)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tgl_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         tgl_prev_q <= tgl_s;
         cs_prev_q  <= cs_s;
      end
   end

   // Event detection. The word and the counter are stable once the
   // toggle or the select rise has crossed, since the link only moves
   // them on clock edges while select is low.
   wire word_evt    = tgl_s ^ tgl_prev_q;
   wire cs_rise     = cs_s & ~cs_prev_q;
   wire cnt_partial = (link_cnt != `CNT_ZERO) && (link_cnt != `CNT_FULL);
   wire part_evt    = cs_rise & cnt_partial; // see [RULE_02] see [RULE_12]
   wire ser_evt     = word_evt | part_evt;
   wire [`WORD_BITS-1:0] ser_word = word_evt ? link_word : link_shift;

   // Register decode.
   wire addr_chan_a = (avs_address == `OFS_CHAN_A);
   wire addr_chan_b = (avs_address == `OFS_CHAN_B);
   wire addr_hold   = (avs_address == `OFS_HOLD);
   wire addr_status = (avs_address == `OFS_STATUS);
   wire addr_soft   = (avs_address == `OFS_SOFT_WORD);
   wire addr_count  = (avs_address == `OFS_WORD_COUNT);
   wire addr_last   = (avs_address == `OFS_LAST_WORD);
   wire soft_lanes  = ((avs_byteenable & `SOFT_LANES) == `SOFT_LANES);
   wire soft_req    = avs_write & addr_soft & soft_lanes;

   // A serial word has priority; a software word waits one cycle.
   wire soft_go     = soft_req & ~ser_evt;

   // Word being applied this cycle.
   wire                  apply   = ser_evt | soft_go;
   wire [`WORD_BITS-1:0] apply_w = ser_evt ? ser_word
                                 : avs_writedata[`WORD_BITS-1:0];

   // Field split of the applied word.
   wire dac_loader_pkg::select_code_e sel =
      dac_loader_pkg::select_code_e'({apply_w[`SELECT_HIGH_POS],
                                      apply_w[`SELECT_LOW_POS]}); // see [RULE_04]
   wire                  pd_req  = apply_w[`POWER_DOWN_POS];
   wire                  fast_in = apply_w[`SPEED_CHOICE_POS];
   wire [`CODE_BITS-1:0] code_in =
      apply_w[`CODE_MSB_POS:`CODE_LSB_POS]; // see [RULE_03]

   // Target selection; a power-down word touches no code latch.
   wire data_ok   = apply & ~pd_req; // see [RULE_08]
   wire load_a    = data_ok & (sel == dac_loader_pkg::SEL_CHAN_A_SYNC);
   wire load_b    = data_ok & (sel == dac_loader_pkg::SEL_CHAN_B_HOLD);
   wire load_hold = data_ok & ((sel == dac_loader_pkg::SEL_CHAN_B_HOLD) |
                               (sel == dac_loader_pkg::SEL_HOLD_ONLY));
   wire rsvd_word = data_ok & (sel == dac_loader_pkg::SEL_RESERVED);
   wire load_ctrl = apply & (pd_req | ~rsvd_word); // see [RULE_15]

   // Channel and hold latches.
   always_ff @(posedge clk) begin
      if (!rst_b) begin // see [RULE_09]
         chan_a_q <= `CODE_RST;
         chan_b_q <= `CODE_RST;
         hold_q   <= `CODE_RST;
      end else begin
         if (load_a) begin // see [RULE_06]
            chan_a_q <= code_in;
         end
         if (load_a) begin // see [RULE_05]
            chan_b_q <= hold_q;
         end else if (load_b) begin
            chan_b_q <= code_in;
         end
         if (load_hold) begin // see [RULE_12]
            hold_q <= code_in;
         end
      end
   end

   // Control latches. Speed is kept across a power-down word because
   // that word carries no meaningful speed bit.
   always_ff @(posedge clk) begin
      if (!rst_b) begin // see [RULE_09]
         speed_q <= 1'b0;
         pdown_q <= 1'b0;
      end else if (load_ctrl) begin
         pdown_q <= pd_req; // see [RULE_08]
         if (!pd_req) begin
            speed_q <= fast_in; // see [RULE_07]
         end
      end
   end

   // Word statistics for software.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         word_count_q <= '0;
         last_word_q  <= `WORD_RST;
         rsvd_seen_q  <= 1'b0;
      end else if (apply) begin
         word_count_q <= word_count_q + COUNT_BITS'(1);
         last_word_q  <= apply_w;
         rsvd_seen_q  <= rsvd_word;
      end
   end

   // Read multiplexer; unmapped and misaligned offsets read as zero.
   logic [`STAT_BITS-1:0] status_w;
   assign status_w[`STAT_FAST_POS]  = speed_q;
   assign status_w[`STAT_PDOWN_POS] = pdown_q;
   assign status_w[`STAT_FRAME_POS] = ~cs_s;
   assign status_w[`STAT_RSVD_POS]  = rsvd_seen_q;

   wire [`BUS_DATA_BITS-1:0] rd_mux =
      addr_chan_a ? `BUS_DATA_BITS'(chan_a_q)     :
      addr_chan_b ? `BUS_DATA_BITS'(chan_b_q)     :
      addr_hold   ? `BUS_DATA_BITS'(hold_q)       :
      addr_status ? `BUS_DATA_BITS'(status_w)     :
      addr_soft   ? `BUS_DATA_BITS'(last_word_q)  :
      addr_count  ? `BUS_DATA_BITS'(word_count_q) :
      addr_last   ? `BUS_DATA_BITS'(last_word_q)  :
                    `BUS_DATA_RST;

   // Reads take one wait cycle so that read data come from a flop.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bus_state_q <= dac_loader_pkg::BUS_IDLE;
         rdata_q     <= `BUS_DATA_RST;
      end else begin
         unique case (bus_state_q)
            dac_loader_pkg::BUS_IDLE: begin
               if (avs_read) begin
                  bus_state_q <= dac_loader_pkg::BUS_RDATA;
                  rdata_q     <= rd_mux;
               end
            end
            dac_loader_pkg::BUS_RDATA: begin
               bus_state_q <= dac_loader_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   wire rd_wait = avs_read & (bus_state_q == dac_loader_pkg::BUS_IDLE);
   wire wr_wait = soft_req & ser_evt;

   assign avs_waitrequest = rd_wait | wr_wait;
   assign avs_readdata    = rdata_q;

   // Outputs.
   assign chan_a_code = chan_a_q;
   assign chan_b_code = chan_b_q;
   assign hold_code   = hold_q;
   assign speed_fast  = speed_q;
   assign power_down  = pdown_q;

endmodule

// *** dv/loader_checker.sv ***
// Port assertions for the dual converter word loader.
`timescale 1ns/1ps
`include "dac_loader_cfg.svh"
module loader_checker #(
   parameter int COUNT_BITS = 16
) (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst_b,
   // Register bus
   input wire logic [`BUS_ADDR_BITS-1:0] avs_address,
   input wire logic                      avs_read,
   input wire logic                      avs_write,
   input wire logic [3:0]                avs_byteenable,
   input wire logic [`BUS_DATA_BITS-1:0] avs_writedata,
   input wire logic [`BUS_DATA_BITS-1:0] avs_readdata,
   input wire logic                      avs_waitrequest,
   // Link
   input wire logic                      sclk,
   input wire logic                      cs_b,
   input wire logic                      din,
   // Latches
   input wire logic [`CODE_BITS-1:0]     chan_a_code,
   input wire logic [`CODE_BITS-1:0]     chan_b_code,
   input wire logic [`CODE_BITS-1:0]     hold_code,
   input wire logic                      speed_fast,
   input wire logic                      power_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   reset_clear_a: assert property (
      $rose(rst_b) |-> chan_a_code == '0 && chan_b_code == '0 &&
      hold_code == '0 && !speed_fast && !power_down)
      else $error("latches not cleared by reset");
   // Eight idle cycles cover the few cycles the link hand-off needs.
   idle_stable_a: assert property (
      cs_b [*8] ##0 !$past(avs_write) |-> $stable(chan_a_code) &&
      $stable(chan_b_code) && $stable(hold_code) && $stable(power_down))
      else $error("latch moved while select idle");
   sync_pair_a: assert property (
      $changed(chan_a_code) |-> chan_b_code == $past(hold_code))
      else $error("channel B not loaded with channel A");
   b_hold_a: assert property (
      $changed(chan_b_code) |-> chan_b_code == hold_code)
      else $error("channel B differs from hold");
   hold_only_a: assert property (
      $changed(hold_code) && $stable(chan_b_code) |-> $stable(chan_a_code))
      else $error("hold-only word touched channel A");
   pdown_keep_a: assert property (
      $rose(power_down) |-> $stable(speed_fast) && $stable(chan_a_code)
      && $stable(hold_code))
      else $error("power-down word changed settings");
   speed_pd_a: assert property (
      $changed(speed_fast) |-> !power_down)
      else $error("speed change left power-down set");
   read_wait_a: assert property ( // Bus timing.
      $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait state wrong");
   cover property ($changed(chan_a_code));
   cover property ($rose(power_down));
   cover property ($rose(avs_read) ##1 !avs_waitrequest);
endmodule

bind dual_dac_serial_word_loader loader_checker #(.COUNT_BITS(COUNT_BITS))
   loader_checker_inst (.clk(clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sclk(sclk), .cs_b(cs_b), .din(din), .chan_a_code(chan_a_code),
   .chan_b_code(chan_b_code), .hold_code(hold_code),
   .speed_fast(speed_fast), .power_down(power_down));

// *** dv/host_model.sv ***
// Behavioural host serial port that frames words onto the link.
`timescale 1ns/1ps
module host_model (
   // Link pins
   output logic sclk,
   output logic cs_b,
   output logic din
);
   // The link clock rests high between frames.
   initial begin
      sclk = 1'b1;
      cs_b = 1'b1;
      din  = 1'b0;
   end
   // Byte-wide hosts send the same bit stream under one low select.
   task automatic send(input logic [19:0] w, input int n);
      #7 cs_b = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #32 sclk = 1'b0;
         #32 sclk = 1'b1;
      end
      #32 cs_b = 1'b1;
      din = ~din;
      #200;
   endtask
   // Toggles clock and data with select high.
   task automatic noise();
      for (int i = 0; i < 8; i++) begin
         #32 sclk = ~sclk;
         din = ~din;
      end
   endtask
endmodule

// *** dv/dual_dac_serial_word_loader_tb.sv ***
// Self-checking bench for the dual converter word loader.
`timescale 1ns/1ps
`include "dac_loader_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   mismatches++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module dual_dac_serial_word_loader_tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sclk;
   logic        cs_b;
   logic        din;
   logic [9:0]  chan_a_code;
   logic [9:0]  chan_b_code;
   logic [9:0]  hold_code;
   logic        speed_fast;
   logic        power_down;
   logic [9:0]  ea = '0;
   logic [9:0]  eb = '0;
   logic [9:0]  eh = '0;
   logic        ef = 1'b0;
   logic        ep = 1'b0;
   logic        er = 1'b0;
   logic [15:0] ec = '0;
   logic [15:0] el = '0;
   logic [31:0] rdata;
   logic [31:0] w;
   int          seed = 32'h1191_5974;
   int          cycles = 0;
   int          mismatches = 0;
   int          samples_checked = 0;
   logic [15:0] words [5] = '{16'h1554, 16'hC3FC, 16'h4AB0, 16'h9FFC,
                              16'h2000};

   dual_dac_serial_word_loader dual_dac_serial_word_loader_inst (
      .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sclk(sclk), .cs_b(cs_b), .din(din), .chan_a_code(chan_a_code),
      .chan_b_code(chan_b_code), .hold_code(hold_code),
      .speed_fast(speed_fast), .power_down(power_down));
   host_model host_model_inst (.sclk(sclk), .cs_b(cs_b), .din(din));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic void apply(input logic [15:0] v);
      ec = ec + 16'h0001;
      el = v;
      er = !v[13] && ({v[15], v[12]} == 2'h3);
      if (v[13]) ep = 1'b1;
      else if ({v[15], v[12]} != 2'h3) begin
         ep = 1'b0;
         ef = v[14];
         case ({v[15], v[12]})
            2'h0: begin
               eb = v[11:2];
               eh = v[11:2];
            end
            2'h1: eh = v[11:2];
            default: begin
               ea = v[11:2];
               eb = eh;
            end
         endcase
      end
   endfunction

   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic check_out();
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK({chan_a_code, chan_b_code, hold_code, speed_fast, power_down},
           {ea, eb, eh, ef, ep})
      rd(`OFS_CHAN_A);
      `CHK(rdata[9:0], ea)
      rd(`OFS_STATUS);
      `CHK(rdata[3:0], {er, 1'b0, ep, ef})
      rd(`OFS_WORD_COUNT);
      `CHK(rdata, {16'h0000, ec})
      rd(`OFS_LAST_WORD);
      `CHK(rdata[15:0], el)
   endtask

   // Words shorter than sixteen bits land right-aligned.
   task automatic ser(input logic [19:0] v, input int n);
      fork
         host_model_inst.send(v, n);
         begin
            wait (cs_b === 1'b0);
            repeat (4) @(posedge clk);
            rd(`OFS_STATUS);
            `CHK(rdata[2], 1'b1)
         end
      join
      apply(16'(v >> (n > 16 ? n - 16 : 0)));
      check_out();
   endtask

   task automatic stop_test();
      $display("Compared %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      check_out();
      foreach (words[i]) ser({4'h0, words[i]}, 16);
      ser(20'h0_00D5, 8);
      ser(20'h8_123F, 20);
      host_model_inst.noise();
      check_out();
      wr(`OFS_SOFT_WORD, 4'hc, 32'h0000_4FFC);
      wr(`OFS_CHAN_A, 4'hf, 32'h0000_03FF);
      check_out();
      rd(5'h1C);
      `CHK(rdata, 32'h0000_0000)
      repeat (12) begin
         w = $random(seed);
         w[1:0] = 2'h0;
         if (w[16]) ser({4'h0, w[15:0]}, 16);
         else begin
            wr(`OFS_SOFT_WORD, 4'hf, {16'h0000, w[15:0]});
            apply(w[15:0]);
            check_out();
         end
      end
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      {ea, eb, eh, ef, ep, er, ec, el} = '0;
      check_out();
      stop_test();
   end
endmodule
